/* File: hw/left_adc_line_input_ctrl.sv */
/*
 * Left ADC line input control: two byte registers that set input ended
 * configuration, mix attenuation and connection, channel power, weak
 * common-mode bias and the left gain-amplifier soft-stepping of the gain.
 * Assumes a one-cycle register request from the control bus decoder, a
 * one-cycle sample-rate tick and the gain target from the gain register.
 */
`timescale 1ns/1ps
`default_nettype none

module left_adc_line_input_ctrl
    import left_adc_line_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire reg_req_s              regReq,
    input  wire logic                  fsTick,
    input  wire logic [GAIN_WIDTH-1:0] gainTarget,
    output var  logic [7:0]            rdData,
    output var  logic                  rdValid,
    output var  line_cfg_s             lineOneCfg,
    output var  line_cfg_s             lineTwoCfg,
    output var  logic                  adcPowerUp,
    output var  logic                  weakBiasEn,
    output var  step_mode_e            stepMode,
    output var  logic [GAIN_WIDTH-1:0] gainApplied
);

    logic [7:0] lineOneReg;
    logic [7:0] lineTwoReg;
    logic       halfPending;

    // reserved codes are treated as disconnected so a stray write cannot
    // inject an unknown attenuation into the mix
    function automatic line_cfg_s decode_line(input logic [7:0] value);
        line_cfg_s cfg;
        cfg.differential = value[CONFIG_BIT];
        cfg.level        = value[LEVEL_MSB:LEVEL_LSB];
        cfg.connected    = (value[LEVEL_MSB:LEVEL_LSB] <= LEVEL_MAX_GAIN);
        return cfg;
    endfunction : decode_line

    function automatic step_mode_e decode_step(input logic [1:0] code);
        case (code)
            STEP_EVERY_FS:  return STEP_FS;
            STEP_EVERY_TWO: return STEP_TWO_FS;
            default:        return STEP_OFF;
        endcase
    endfunction : decode_step

    wire logic writeOne = regReq.wrEn && (regReq.addr == LINE_ONE_ADDR);
    wire logic writeTwo = regReq.wrEn && (regReq.addr == LINE_TWO_ADDR);

    // register storage
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            lineOneReg <= LINE_ONE_RESET;
        end
        else if (writeOne)
        begin
            lineOneReg <= regReq.wrData;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            lineTwoReg <= LINE_TWO_RESET;
        end
        else if (writeTwo)
        begin
            lineTwoReg <= {regReq.wrData[7:2], 2'h0};
        end
    end

    // register read-back, one cycle after the request
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            rdData  <= 8'h00;
            rdValid <= 1'b0;
        end
        else
        begin
            rdValid <= regReq.rdEn;
            if (regReq.rdEn)
            begin
                case (regReq.addr)
                    LINE_ONE_ADDR: rdData <= lineOneReg;
                    LINE_TWO_ADDR: rdData <= {lineTwoReg[7:2], 2'h0};
                    default:       rdData <= 8'h00;
                endcase
            end
        end
    end

    // decoded controls follow the registers by one cycle
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            lineOneCfg <= decode_line(LINE_ONE_RESET);
            lineTwoCfg <= decode_line(LINE_TWO_RESET);
            adcPowerUp <= 1'b0;
            weakBiasEn <= 1'b0;
            stepMode   <= STEP_FS;
        end
        else
        begin
            lineOneCfg <= decode_line(lineOneReg);
            lineTwoCfg <= decode_line(lineTwoReg);
            adcPowerUp <= lineOneReg[POWER_BIT];
            weakBiasEn <= lineTwoReg[BIAS_BIT];
            stepMode   <= decode_step(lineOneReg[STEP_MSB:STEP_LSB]);
        end
    end

    // soft-stepping: only one gain code per interval to avoid zipper noise
    wire logic stepNow = fsTick &&
        ((stepMode == STEP_FS) || (stepMode == STEP_TWO_FS && halfPending));

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            halfPending <= 1'b0;
        end
        else if (stepMode != STEP_TWO_FS)
        begin
            halfPending <= 1'b0;
        end
        else if (fsTick)
        begin
            halfPending <= !halfPending;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            gainApplied <= '0;
        end
        else if (stepMode == STEP_OFF)
        begin
            gainApplied <= gainTarget;
        end
        else if (stepNow && gainApplied < gainTarget)
        begin
            gainApplied <= gainApplied + 7'h01;
        end
        else if (stepNow && gainApplied > gainTarget)
        begin
            gainApplied <= gainApplied - 7'h01;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    config_follows_a: assert property (
        writeOne |-> ##2 lineOneCfg.differential == $past(regReq.wrData[7], 2))
        else $error("first input config does not follow write");

    disconnect_code_a: assert property (
        lineOneCfg.level == LEVEL_DISCONNECT |-> !lineOneCfg.connected)
        else $error("disconnect code left input connected");

    auto_connect_a: assert property (
        writeOne && regReq.wrData[6:3] <= LEVEL_MAX_GAIN
        ##1 !writeOne |-> ##1 lineOneCfg.connected)
        else $error("valid gain code did not connect input");

    second_level_a: assert property (
        writeTwo |-> ##2 lineTwoCfg.level == $past(regReq.wrData[6:3], 2))
        else $error("second input level does not follow write");

    power_follows_a: assert property (
        writeOne |-> ##2 adcPowerUp == $past(regReq.wrData[2], 2))
        else $error("adc power does not follow write");

    step_decode_a: assert property (
        writeOne && regReq.wrData[1]
        ##1 !writeOne |-> ##1 stepMode == STEP_OFF)
        else $error("step codes 10 and 11 did not disable stepping");

    bias_follows_a: assert property (
        writeTwo |-> ##2 weakBiasEn == $past(regReq.wrData[2], 2))
        else $error("weak bias does not follow write");

    reserved_zero_a: assert property (
        regReq.rdEn && regReq.addr == LINE_TWO_ADDR |=> rdData[1:0] == 2'h0)
        else $error("reserved bits read nonzero");

    single_step_a: assert property (
        stepMode != STEP_OFF && !fsTick |=> $stable(gainApplied))
        else $error("gain moved without a sample tick");

    step_size_a: assert property (
        stepMode == STEP_FS && $past(stepMode) == STEP_FS
        |-> (gainApplied - $past(gainApplied) <= 7'h01) ||
            ($past(gainApplied) - gainApplied <= 7'h01))
        else $error("gain moved more than one step");

endmodule : left_adc_line_input_ctrl

`default_nettype wire

/* File: hw/left_adc_line_pkg.sv */
/*
 * Constants and carrier types for the left ADC line input control registers.
 * Assumes a byte-wide register port driven by the control serial bus decoder.
 */
package left_adc_line_pkg;

    localparam logic [7:0] LINE_ONE_ADDR    = 8'h13;
    localparam logic [7:0] LINE_TWO_ADDR    = 8'h14;

    localparam logic [7:0] LINE_ONE_RESET   = 8'h78;
    localparam logic [7:0] LINE_TWO_RESET   = 8'h78;

    localparam int CONFIG_BIT               = 7;
    localparam int LEVEL_MSB                = 6;
    localparam int LEVEL_LSB                = 3;
    localparam int POWER_BIT                = 2;
    localparam int BIAS_BIT                 = 2;
    localparam int STEP_MSB                 = 1;
    localparam int STEP_LSB                 = 0;

    localparam logic [3:0] LEVEL_MAX_GAIN   = 4'h8;
    localparam logic [3:0] LEVEL_DISCONNECT = 4'hF;

    localparam logic [1:0] STEP_EVERY_FS    = 2'h0;
    localparam logic [1:0] STEP_EVERY_TWO   = 2'h1;

    localparam int GAIN_WIDTH               = 7;

    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } reg_req_s;

    typedef struct packed {
        logic       differential;
        logic       connected;
        logic [3:0] level;
    } line_cfg_s;

    typedef enum logic [1:0] {
        STEP_FS,
        STEP_TWO_FS,
        STEP_OFF
    } step_mode_e;

endpackage : left_adc_line_pkg

/* File: tb/host_model.sv */
/* host model: one-cycle register requests at the falling edge.
   assumes the bench calls wr and rd one at a time. */
`timescale 1ns/1ps
`default_nettype none
module host_model
    import left_adc_line_pkg::*;
(
    input  wire logic       clk,
    output var  reg_req_s   regReq,
    input  wire logic [7:0] rdData,
    input  wire logic       rdValid
);
    logic allowBad = 1'b0;
    initial regReq = '{1'b0, 1'b0, 8'hA5, 8'h5A};
    // idle lines show the inverse, so a held copy cannot pass unseen
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        if (a == LINE_TWO_ADDR && !allowBad)
            d[1:0] = 2'h0;
        regReq <= '{1'b1, 1'b0, a, d};
        @(negedge clk);
        regReq <= '{1'b0, 1'b0, ~a, ~d};
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic v);
        @(negedge clk);
        regReq <= '{1'b0, 1'b1, a, ~a};
        @(negedge clk);
        d = rdData;
        v = rdValid;
        regReq <= '{1'b0, 1'b0, ~a, a};
    endtask : rd
endmodule : host_model
`default_nettype wire

/* File: tb/testbench.sv */
/* testbench: register decode, read-back and gain stepping.
   assumes host_model drives the register port. */
`timescale 1ns/1ps
`default_nettype none
module testbench
    import left_adc_line_pkg::*;
;
    logic                  clk;
    logic                  reset_n;
    logic                  fsTick;
    logic [GAIN_WIDTH-1:0] gainTarget;
    reg_req_s              regReq;
    logic [7:0]            rdData;
    logic                  rdValid;
    line_cfg_s             lineOneCfg;
    line_cfg_s             lineTwoCfg;
    logic                  adcPowerUp;
    logic                  weakBiasEn;
    step_mode_e            stepMode;
    logic [GAIN_WIDTH-1:0] gainApplied;
    int                    err_count = 0;
    int                    compares = 0;
    logic [7:0]            rv;
    logic                  v;
    logic [3:0]            lvl;
    logic                  conn;
    step_mode_e            em;

    left_adc_line_input_ctrl DUT (.clk(clk), .reset_n(reset_n),
        .regReq(regReq), .fsTick(fsTick), .gainTarget(gainTarget),
        .rdData(rdData), .rdValid(rdValid), .lineOneCfg(lineOneCfg),
        .lineTwoCfg(lineTwoCfg), .adcPowerUp(adcPowerUp),
        .weakBiasEn(weakBiasEn), .stepMode(stepMode),
        .gainApplied(gainApplied));
    host_model host (.clk(clk), .regReq(regReq), .rdData(rdData),
        .rdValid(rdValid));

    always #25 clk = ~clk;

    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask : chk
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, rv, v);
        chk("rdValid", 8'h01, {7'h0, v});
        chk("rdData", e, rv);
    endtask : rdchk
    task automatic tick;
        @(negedge clk);
        fsTick = 1'b1;
        @(negedge clk);
        fsTick = 1'b0;
    endtask : tick
    task automatic report_and_stop;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop

    initial
    begin
        clk = 1'b0;
        reset_n = 1'b0;
        fsTick = 1'b0;
        gainTarget = 7'h00;
        repeat (12) @(negedge clk);
        reset_n = 1'b1;
        rdchk(LINE_ONE_ADDR, LINE_ONE_RESET);
        rdchk(LINE_TWO_ADDR, LINE_TWO_RESET);
        chk("cfgOne", 8'h0F, 8'(lineOneCfg));
        $display("reset test done");
        for (int i = 0; i < 10; i++)
        begin
            lvl = (i < 9) ? 4'(i) : LEVEL_DISCONNECT;
            host.wr(LINE_ONE_ADDR, {i[0], lvl, i[1], i[1:0]});
            host.wr(LINE_TWO_ADDR, {~i[0], lvl, i[2], 2'h0});
            @(negedge clk);
            conn = (lvl != LEVEL_DISCONNECT);
            chk("cfgOne", {2'h0, i[0], conn, lvl}, 8'(lineOneCfg));
            chk("cfgTwo", {2'h0, ~i[0], conn, lvl}, 8'(lineTwoCfg));
            chk("power", {7'h0, i[1]}, {7'h0, adcPowerUp});
            chk("bias", {7'h0, i[2]}, {7'h0, weakBiasEn});
            em = (i[1:0] == 0) ? STEP_FS :
                 (i[1:0] == 1) ? STEP_TWO_FS : STEP_OFF;
            chk("step", 8'(em), 8'(stepMode));
            rdchk(LINE_TWO_ADDR, {~i[0], lvl, i[2], 2'h0});
        end
        $display("decode test done");
        host.allowBad = 1'b1;
        host.wr(LINE_TWO_ADDR, 8'h07);
        rdchk(LINE_TWO_ADDR, 8'h04);
        host.wr(8'h15, 8'hFF);
        rdchk(8'h15, 8'h00);
        rdchk(LINE_ONE_ADDR, 8'hF9);
        $display("access test done");
        host.wr(LINE_ONE_ADDR, 8'h00);
        gainTarget = 7'h03;
        for (int k = 1; k < 5; k++)
        begin
            tick();
            chk("gainFs", 8'(k < 3 ? k : 3), 8'(gainApplied));
        end
        host.wr(LINE_ONE_ADDR, 8'h01);
        gainTarget = 7'h00;
        for (int k = 1; k < 5; k++)
        begin
            tick();
            chk("gainTwo", 8'(3 - k / 2), 8'(gainApplied));
        end
        host.wr(LINE_ONE_ADDR, 8'h02);
        @(negedge clk);
        gainTarget = 7'h40;
        @(negedge clk);
        chk("gainOff", 8'h40, 8'(gainApplied));
        $display("step test done");
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
